// >>> hdl/pcicfg_header_regs.sv
// configuration header registers: window base, subsystem id, cap, interrupt
`timescale 1ns/100ps
module pcicfg_header_regs (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic cfg_req_i,
    input wire logic cfg_wr_i,
    input wire logic [pcicfg_pkg::CFG_AW-1:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic cfg_done_o,
    output logic cfg_retry_o,
    output logic [31:0] cfg_rdata_o,
    input wire logic lcl_sid_wr_i,
    input wire logic [31:0] lcl_sid_data_i,
    input wire logic new_cap_en_i,
    input wire logic mem_valid_i,
    input wire logic [31:0] mem_addr_i,
    output logic window_hit_o,
    output logic [pcicfg_pkg::BASE_W-1:0] window_base_value_o,
    output logic prefetch_o,
    output logic sid_loaded_o
);
    import pcicfg_pkg::*;

    logic [BASE_W-1:0] window_base_value;
    logic prefetch;
    logic [31:0] subsystem_identification;
    logic sid_loaded;
    logic [7:0] int_line;
    logic [31:0] next_rdata;
    logic sid_blocked;
    logic wr_go;

    function automatic logic is_reserved(input logic [CFG_AW-1:0] a);
        is_reserved = (a >= ADDR_RSVD_LO) && (a <= ADDR_RSVD_HI);
    endfunction

    function automatic logic hits(input logic [CFG_AW-1:0] a,
                                  input logic [CFG_AW-1:0] reg_addr);
        // word granular: the low two address bits do not select
        hits = a[CFG_AW-1:2] == reg_addr[CFG_AW-1:2];
    endfunction

    // host access to the id before the local load must be retried
    assign sid_blocked = hits(cfg_addr_i, ADDR_SID) && !sid_loaded;
    assign wr_go = cfg_req_i && cfg_wr_i && !sid_blocked;

    // window base, host programmed
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            window_base_value <= BASE_RST;
        end else if (wr_go && hits(cfg_addr_i, ADDR_BAR) && cfg_be_i[3]) begin
            window_base_value <= cfg_wdata_i[BASE_MSB:BASE_LSB];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            prefetch <= PREF_RST;
        end else if (wr_go && hits(cfg_addr_i, ADDR_BAR) && cfg_be_i[0]) begin
            prefetch <= cfg_wdata_i[PREF_BIT];
        end
    end

    // only the local side port reaches the id; host writes never land
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            subsystem_identification <= SID_RST;
        end else if (lcl_sid_wr_i) begin
            subsystem_identification <= lcl_sid_data_i;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            sid_loaded <= 1'b0;
        end else if (lcl_sid_wr_i) begin
            sid_loaded <= 1'b1;
        end
    end

    // routing byte is stored and read back in the low byte of the interrupt word; nothing else uses it
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            int_line <= INT_LINE_RST;
        end else if (wr_go && hits(cfg_addr_i, ADDR_INT) && cfg_be_i[0]) begin
            int_line <= cfg_wdata_i[7:0];
        end
    end

    // read mux; if-chain by address
    always_comb begin
        next_rdata = ZERO_WORD;
        if (hits(cfg_addr_i, ADDR_BAR)) begin
            next_rdata[BASE_MSB:BASE_LSB] = window_base_value;
            next_rdata[PREF_BIT] = prefetch;
            next_rdata[2:1] = BAR_TYPE;
            next_rdata[0] = BAR_MEM_IND;
        end else if (is_reserved(cfg_addr_i)) begin
            next_rdata = ZERO_WORD;
        end else if (hits(cfg_addr_i, ADDR_SID)) begin
            next_rdata = subsystem_identification;
        end else if (hits(cfg_addr_i, ADDR_CAP)) begin
            // pointer withheld while the capability list is off
            if (new_cap_en_i) begin
                next_rdata[7:0] = CAP_PTR;
            end
        end else if (hits(cfg_addr_i, ADDR_INT)) begin
            next_rdata = {MAX_LAT, MIN_GNT, INT_PIN, int_line};
        end
    end

    // one-cycle answer to every request; writes to fixed bits just complete
    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cfg_done_o <= 1'b0;
            cfg_retry_o <= 1'b0;
        end else begin
            cfg_done_o <= cfg_req_i && !sid_blocked;
            cfg_retry_o <= cfg_req_i && sid_blocked;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            cfg_rdata_o <= ZERO_WORD;
        end else if (cfg_req_i && !cfg_wr_i && !sid_blocked) begin
            cfg_rdata_o <= next_rdata;
        end else begin
            cfg_rdata_o <= ZERO_WORD;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            window_base_value_o <= BASE_RST;
            prefetch_o <= PREF_RST;
            sid_loaded_o <= 1'b0;
        end else begin
            window_base_value_o <= window_base_value;
            prefetch_o <= prefetch;
            sid_loaded_o <= sid_loaded;
        end
    end

    // host must program the base before using the window
    pcicfg_window_dec #(
        .WIN_BITS(WIN_ADDR_BITS)
    ) u_window_dec (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .base_i(window_base_value),
        .mem_valid_i(mem_valid_i),
        .mem_addr_i(mem_addr_i),
        .hit_o(window_hit_o)
    );

    sid_retry_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && hits(cfg_addr_i, ADDR_SID) && !sid_loaded
        |=> cfg_retry_o && !cfg_done_o)
        else $error("unloaded id access not retried");

    sid_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && !cfg_wr_i && hits(cfg_addr_i, ADDR_SID) && sid_loaded
        && !lcl_sid_wr_i
        |=> cfg_done_o && cfg_rdata_o == $past(subsystem_identification))
        else $error("subsystem id read mismatch");

    sid_host_ro_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !lcl_sid_wr_i |=> $stable(subsystem_identification))
        else $error("subsystem id changed without local write");

    bar_fixed_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && !cfg_wr_i && hits(cfg_addr_i, ADDR_BAR)
        |=> cfg_rdata_o[2:0] == 3'h0 && cfg_rdata_o[27:4] == 24'h00_0000)
        else $error("base register fixed bits wrong");

    pref_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && cfg_wr_i && hits(cfg_addr_i, ADDR_BAR) && cfg_be_i[0]
        |=> prefetch == $past(cfg_wdata_i[PREF_BIT]))
        else $error("prefetch bit not written");

    rsvd_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && !cfg_wr_i && is_reserved(cfg_addr_i)
        |=> cfg_done_o && cfg_rdata_o == ZERO_WORD)
        else $error("reserved slot read nonzero");

    cap_ptr_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && !cfg_wr_i && hits(cfg_addr_i, ADDR_CAP)
        |=> cfg_rdata_o == ($past(new_cap_en_i) ? 32'h0000_0050
                                                : ZERO_WORD))
        else $error("capability pointer read wrong");

    int_info_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && !cfg_wr_i && hits(cfg_addr_i, ADDR_INT)
        |=> cfg_rdata_o[31:8] == 24'h28_1401)
        else $error("interrupt info fixed bytes wrong");

    int_line_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && cfg_wr_i && hits(cfg_addr_i, ADDR_INT) && cfg_be_i[0]
        |=> int_line == $past(cfg_wdata_i[7:0]) && cfg_done_o)
        else $error("interrupt line not stored");

    ro_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && cfg_wr_i && !hits(cfg_addr_i, ADDR_BAR)
        && !hits(cfg_addr_i, ADDR_SID)
        |=> cfg_done_o && !cfg_retry_o && $stable(window_base_value)
        && $stable(prefetch))
        else $error("read-only write misbehaved");

    term_excl_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !(cfg_done_o && cfg_retry_o))
        else $error("done and retry together");

    done_follows_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && !sid_blocked |=> cfg_done_o && !cfg_retry_o)
        else $error("request not completed");

    idle_quiet_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !cfg_req_i
        |=> !cfg_done_o && !cfg_retry_o && cfg_rdata_o == ZERO_WORD)
        else $error("answer without request");

    loaded_sticky_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        sid_loaded |=> sid_loaded)
        else $error("load flag dropped");

    local_load_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        lcl_sid_wr_i |=> sid_loaded
        && subsystem_identification == $past(lcl_sid_data_i))
        else $error("local id load lost");

    base_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && cfg_wr_i && hits(cfg_addr_i, ADDR_BAR) && cfg_be_i[3]
        |=> window_base_value == $past(cfg_wdata_i[BASE_MSB:BASE_LSB]))
        else $error("base write lost");

    base_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !(cfg_req_i && cfg_wr_i)
        |=> $stable(window_base_value) && $stable(prefetch))
        else $error("base changed without write");

    base_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && !cfg_wr_i && hits(cfg_addr_i, ADDR_BAR)
        |=> cfg_rdata_o[BASE_MSB:BASE_LSB] == $past(window_base_value))
        else $error("base read mismatch");

    wr_data_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && cfg_wr_i |=> cfg_rdata_o == ZERO_WORD)
        else $error("write returned data");

    line_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        !(cfg_req_i && cfg_wr_i && hits(cfg_addr_i, ADDR_INT))
        |=> $stable(int_line))
        else $error("interrupt line changed without write");

    out_copy_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        1'b1 |=> window_base_value_o == $past(window_base_value)
        && prefetch_o == $past(prefetch)
        && sid_loaded_o == $past(sid_loaded))
        else $error("status outputs lag wrong");

    rsvd_write_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && cfg_wr_i && is_reserved(cfg_addr_i)
        |=> cfg_done_o && $stable(window_base_value)
        && $stable(int_line))
        else $error("reserved write had effect");

    line_read_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && !cfg_wr_i && hits(cfg_addr_i, ADDR_INT)
        |=> cfg_rdata_o[7:0] == $past(int_line))
        else $error("interrupt line read mismatch");

    sid_wr_drop_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && cfg_wr_i && hits(cfg_addr_i, ADDR_SID) && !lcl_sid_wr_i
        |=> $stable(subsystem_identification))
        else $error("host write reached subsystem id");

    cap_upper_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        cfg_req_i && !cfg_wr_i && hits(cfg_addr_i, ADDR_CAP)
        |=> cfg_rdata_o[31:8] == 24'h00_0000)
        else $error("capability upper bits nonzero");
endmodule // pcicfg_header_regs

// >>> hdl/pcicfg_pkg.sv
// constants for the bridge configuration header register slice
package pcicfg_pkg;
    localparam int CFG_AW = 16;
    localparam logic [15:0] ADDR_BAR = 16'h2010;
    localparam logic [15:0] ADDR_RSVD_LO = 16'h2014;
    localparam logic [15:0] ADDR_RSVD_HI = 16'h2028;
    localparam logic [15:0] ADDR_SID = 16'h202C;
    localparam logic [15:0] ADDR_CAP = 16'h2034;
    localparam logic [15:0] ADDR_INT = 16'h203C;
    localparam int BASE_MSB = 31;
    localparam int BASE_LSB = 28;
    localparam int BASE_W = 4;
    localparam int PREF_BIT = 3;
    localparam int WIN_ADDR_BITS = 26;
    localparam logic [3:0] BASE_RST = 4'h0;
    localparam logic PREF_RST = 1'b0;
    localparam logic [1:0] BAR_TYPE = 2'h0;
    localparam logic BAR_MEM_IND = 1'b0;
    localparam logic [31:0] SID_RST = 32'h0000_0000;
    localparam logic [7:0] CAP_PTR = 8'h50;
    localparam logic [7:0] MAX_LAT = 8'h28;
    localparam logic [7:0] MIN_GNT = 8'h14;
    localparam logic [7:0] INT_PIN = 8'h01;
    localparam logic [7:0] INT_LINE_RST = 8'h00;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// >>> hdl/pcicfg_window_dec.sv
// memory window decoder for the configured base
`timescale 1ns/100ps
module pcicfg_window_dec #(
    parameter int WIN_BITS = pcicfg_pkg::WIN_ADDR_BITS
) (
    input wire logic mclk_i,
    input wire logic rst_b_i,
    input wire logic [pcicfg_pkg::BASE_W-1:0] base_i,
    input wire logic mem_valid_i,
    input wire logic [31:0] mem_addr_i,
    output logic hit_o
);
    import pcicfg_pkg::*;

    // the base field is coarser than the window; bits between must be zero
    localparam int GAP_W = BASE_LSB - WIN_BITS;

    always_ff @(posedge mclk_i) begin
        if (!rst_b_i) begin
            hit_o <= 1'b0;
        end else begin
            hit_o <= mem_valid_i
                && mem_addr_i[BASE_MSB:BASE_LSB] == base_i
                && mem_addr_i[BASE_LSB-1:WIN_BITS] == {GAP_W{1'b0}};
        end
    end

    hit_window_a: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        mem_valid_i && mem_addr_i[BASE_MSB:BASE_LSB] != base_i
        |=> !hit_o)
        else $error("window hit outside programmed base");
endmodule // pcicfg_window_dec

// >>> tb/pcicfg_host_model.sv
// host side model issuing configuration cycles
`timescale 1ns/100ps
module pcicfg_host_model (
    input wire logic mclk_i,
    input wire logic done_i,
    input wire logic retry_i,
    input wire logic [31:0] rdata_i,
    output logic req_o,
    output logic wr_o,
    output logic [15:0] addr_o,
    output logic [3:0] be_o,
    output logic [31:0] wdata_o
);
    initial begin
        req_o = 1'b0;
        wr_o = 1'b0;
        addr_o = 16'h0000;
        be_o = 4'h0;
        wdata_o = 32'h0000_0000;
    end
    // one pulse per call; fields scrambled after the take edge
    // so the design cannot lean on stale values
    task automatic xfer(input logic w, input logic [15:0] a,
        input logic [3:0] b, input logic [31:0] d,
        output logic [31:0] q, output logic rt, output logic dn);
        @(posedge mclk_i);
        req_o <= 1'b1;
        wr_o <= w;
        addr_o <= a;
        be_o <= b;
        wdata_o <= d;
        @(posedge mclk_i);
        req_o <= 1'b0;
        wr_o <= ~w;
        addr_o <= ~a;
        be_o <= ~b;
        wdata_o <= ~d;
        #1;
        q = rdata_i;
        rt = retry_i;
        dn = done_i;
    endtask
endmodule // pcicfg_host_model

// >>> tb/test_pci_bridge_config_header_regs.sv
// self-checking bench for the configuration header registers
`timescale 1ns/100ps
module test_pci_bridge_config_header_regs;
    import pcicfg_pkg::*;
    logic mclk_i, rst_b_i, req, wr, done, retry, lwr, cap, mv, hit, pref, ld;
    logic [15:0] addr;
    logic [3:0] be, base;
    logic [31:0] wd, rdat, ldat, ma;
    int err_count, num_checks;
    pcicfg_header_regs i_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .cfg_req_i(req), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_be_i(be),
        .cfg_wdata_i(wd), .cfg_done_o(done), .cfg_retry_o(retry),
        .cfg_rdata_o(rdat), .lcl_sid_wr_i(lwr), .lcl_sid_data_i(ldat),
        .new_cap_en_i(cap), .mem_valid_i(mv), .mem_addr_i(ma),
        .window_hit_o(hit), .window_base_value_o(base), .prefetch_o(pref),
        .sid_loaded_o(ld));
    pcicfg_host_model i_host (.mclk_i(mclk_i), .done_i(done),
        .retry_i(retry), .rdata_i(rdat), .req_o(req), .wr_o(wr),
        .addr_o(addr), .be_o(be), .wdata_o(wd));
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s,
        input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a,
        input logic [3:0] b, input logic [31:0] d, input logic [31:0] e,
        input logic rte);
        logic [31:0] q;
        logic rt, dn;
        i_host.xfer(w, a, b, d, q, rt, dn);
        chk($sformatf("retry %h", a), {31'h0, rt}, {31'h0, rte});
        chk($sformatf("done %h", a), {31'h0, dn}, {31'h0, ~rte});
        chk($sformatf("rdata %h", a), q, w ? ZERO_WORD : e);
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        acc(1'b0, a, 4'hF, ZERO_WORD, e, 1'b0);
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [3:0] b,
        input logic [31:0] d);
        acc(1'b1, a, b, d, ZERO_WORD, 1'b0);
    endtask
    task automatic hit_chk(input logic v, input logic [31:0] a, input logic e);
        @(posedge mclk_i);
        mv <= v;
        ma <= a;
        @(posedge mclk_i);
        #1 chk("window hit", {31'h0, hit}, {31'h0, e});
    endtask
    task automatic do_reset;
        @(posedge mclk_i);
        rst_b_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        rst_b_i <= 1'b1;
    endtask
    initial begin
        repeat (2000) @(posedge mclk_i);
        err_count++;
        print_verdict;
    end
    initial begin
        rst_b_i = 1'b0;
        lwr = 1'b0;
        ldat = 32'h0000_0000;
        cap = 1'b0;
        mv = 1'b0;
        ma = 32'h0000_0000;
        err_count = 0;
        num_checks = 0;
        do_reset;
        rd(ADDR_BAR, ZERO_WORD);
        chk("loaded", {31'h0, ld}, ZERO_WORD);
        acc(1'b0, ADDR_SID, 4'hF, ZERO_WORD, ZERO_WORD, 1'b1);
        acc(1'b1, ADDR_SID, 4'hF, 32'hFFFF_FFFF, ZERO_WORD, 1'b1);
        rd(ADDR_INT, 32'h2814_0100);
        wr_reg(ADDR_BAR, 4'hF, 32'hFFFF_FFFF);
        rd(ADDR_BAR, 32'hF000_0008);
        wr_reg(ADDR_BAR, 4'h0, ZERO_WORD);
        rd(ADDR_BAR, 32'hF000_0008);
        // base is programmed before any window traffic
        wr_reg(ADDR_BAR, 4'hF, 32'h3000_0000);
        rd(ADDR_BAR, 32'h3000_0000);
        chk("base", {28'h0, base}, 32'h0000_0003);
        chk("prefetch", {31'h0, pref}, ZERO_WORD);
        hit_chk(1'b1, 32'h3000_0004, 1'b1);
        hit_chk(1'b1, 32'h3400_0000, 1'b0);
        hit_chk(1'b1, 32'h2000_0000, 1'b0);
        hit_chk(1'b0, 32'h3000_0000, 1'b0);
        for (int a = ADDR_RSVD_LO; a <= ADDR_RSVD_HI; a += 4) begin
            wr_reg(a[15:0], 4'hF, 32'hFFFF_FFFF);
            rd(a[15:0], ZERO_WORD);
        end
        // local processor loads the subsystem id early in bring-up
        @(posedge mclk_i);
        lwr <= 1'b1;
        ldat <= 32'h1234_ABCD;
        @(posedge mclk_i);
        lwr <= 1'b0;
        ldat <= 32'hEDCB_5432;
        @(posedge mclk_i);
        #1 chk("loaded", {31'h0, ld}, 32'h0000_0001);
        rd(ADDR_SID, 32'h1234_ABCD);
        wr_reg(ADDR_SID, 4'hF, ZERO_WORD);
        rd(ADDR_SID, 32'h1234_ABCD);
        @(posedge mclk_i);
        cap <= 1'b1;
        rd(ADDR_CAP, 32'h0000_0050);
        wr_reg(ADDR_CAP, 4'hF, 32'hFFFF_FFFF);
        rd(ADDR_CAP, 32'h0000_0050);
        @(posedge mclk_i);
        cap <= 1'b0;
        rd(ADDR_CAP, ZERO_WORD);
        wr_reg(ADDR_INT, 4'hF, 32'hFFFF_FFA5);
        rd(ADDR_INT, 32'h2814_01A5);
        rd(16'h2040, ZERO_WORD);
        // a second reset must drop the load and the programmed fields
        do_reset;
        acc(1'b0, ADDR_SID, 4'hF, ZERO_WORD, ZERO_WORD, 1'b1);
        rd(ADDR_BAR, ZERO_WORD);
        rd(ADDR_INT, 32'h2814_0100);
        print_verdict;
    end
endmodule // test_pci_bridge_config_header_regs
